// file: common/sar_pkg.sv
// Package for the serial readout of the successive-approximation converter
package sar_pkg;
   // Result and frame layout
   localparam int RES_BITS = 10;
   localparam int SUB_BITS = 2;
   localparam int LEAD_ZEROS = 3;
   localparam int FRAME_BITS = LEAD_ZEROS + RES_BITS + SUB_BITS;
   localparam int CNT_W = 5;
   // Edge that shows the first result bit (third rising edge)
   localparam logic [CNT_W-1:0] MSB_EDGE = 5'h03;
   localparam logic [CNT_W-1:0] LAST_EDGE = 5'h0e;
   localparam logic [CNT_W-1:0] CNT_SAT = 5'h1f;
   // Output delay after a rising link clock edge
   localparam int DOUT_DELAY_NS = 20;
   localparam int CORE_PERIOD_NS = 25;
   // Longest time: round down, at least one cycle
   localparam int DOUT_DELAY_CYC = (DOUT_DELAY_NS / CORE_PERIOD_NS) < 1 ? 1 : (DOUT_DELAY_NS / CORE_PERIOD_NS);

   typedef struct packed {
      logic [RES_BITS-1:0] code;
      logic [SUB_BITS-1:0] sub;
   } sar_result_t;

   typedef struct packed {
      logic data;
      logic oe;
   } sar_pin_t;
endpackage

// file: rtl/sar_readout.sv
// Conversion control and serial readout of the converter
//
// Function
// - Chip select fall holds sample, drives low
// - Output changes only after rising clock edge
// - Three zeros, then MSB on third edge
// - Frame: zeros, result MSB first, sub-bits
// - Extra clocks give zeros, no disturbance
// - Sub-bits then zeros after LSB
// - Byte split: 3 zeros+5, 5+2+1 zero
// - Straight binary, step is reference/1024
// - Reference off while shutdown low
// - Output high impedance while select high
// - Shutdown low gives low-power mode
`timescale 1ns/10ps
`default_nettype none
module sar_readout
   import sar_pkg::*;
(
   input wire logic i_core_clk,                     // Core clock, 40 MHz
   input wire logic i_rst_b,                        // Async reset, active low
   input wire logic i_sclk,                         // Link serial clock
   input wire logic i_cs_b,                         // Chip select, active low
   input wire logic i_shutdown_n,                   // Shutdown, active low
   input wire logic [sar_pkg::RES_BITS-1:0] i_code, // Converted code, straight binary
   input wire logic [sar_pkg::SUB_BITS-1:0] i_sub,  // Sub-bits of the conversion
   output logic o_dout,                             // Serial data out
   output logic o_dout_oe,                          // Serial data drive enable
   output logic o_hold,                             // Sampler in hold
   output logic o_ref_en,                           // Internal reference enable
   output logic o_low_power                         // Low-power mode
);
   import sar_pkg::*;

   // ****************************************
   // Link domain: frame counter and shifter
   // ****************************************
   // Chip select high acts as asynchronous frame reset of the link logic
   logic frame_rst_b;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [FRAME_BITS-1:0] shift_reg, shift_next;
   logic bit_reg, bit_next;
   logic ld_reg, ld_next;
   sar_result_t res;

   // ****************************************
   // Helper functions
   // ****************************************
   // Frame word: leading zeros, result MSB first, sub-bits
   function automatic logic [FRAME_BITS-1:0] frame_word(input sar_result_t r);
      return {{LEAD_ZEROS{1'b0}}, r.code, r.sub};
   endfunction

   // Edge counter stops at its top code, so long frames never wrap
   function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] c);
      logic [CNT_W-1:0] n;
      n = c;
      if (c != CNT_SAT) begin
         n = c + 5'h01;
      end
      return n;
   endfunction

   // Pin drive: data bit and enabled in a frame, low and released outside it
   function automatic sar_pin_t pin_drive(input logic cs_b, input logic d);
      sar_pin_t p;
      p.oe = ~cs_b;
      p.data = cs_b ? 1'b0 : d;
      return p;
   endfunction

   assign frame_rst_b = i_rst_b & ~i_cs_b;
   assign res.code = i_code;
   assign res.sub = i_sub;

   always_comb begin
      cnt_next = count_up(cnt_reg);
      ld_next = 1'b1;
      // First rising edge loads the word, later edges shift it up
      if (!ld_reg) begin
         shift_next = frame_word(res);
         bit_next = 1'b0;
      end else begin
         shift_next = {shift_reg[FRAME_BITS-2:0], 1'b0};
         // Select fall level is the first zero, rises 1 and 2 the others
         bit_next = shift_reg[FRAME_BITS-LEAD_ZEROS];
      end
   end

   always_ff @(posedge i_sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         cnt_reg <= '0;
         shift_reg <= '0;
         bit_reg <= 1'b0;
         ld_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         bit_reg <= bit_next;
         ld_reg <= ld_next;
      end
   end

   // ****************************************
   // Core domain: pin synchronisers
   // ****************************************
   // Chip select pin, idles high
   logic cs_s1_reg, cs_s1_next, cs_s2_reg, cs_s2_next;

   always_comb begin
      cs_s1_next = i_cs_b;
      cs_s2_next = cs_s1_reg;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
      end else begin
         cs_s1_reg <= cs_s1_next;
         cs_s2_reg <= cs_s2_next;
      end
   end

   // Shutdown pin, idles high
   logic shutdown_n_s1_reg, shutdown_n_s1_next, shutdown_n_s2_reg, shutdown_n_s2_next;

   always_comb begin
      shutdown_n_s1_next = i_shutdown_n;
      shutdown_n_s2_next = shutdown_n_s1_reg;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         shutdown_n_s1_reg <= 1'b1;
         shutdown_n_s2_reg <= 1'b1;
      end else begin
         shutdown_n_s1_reg <= shutdown_n_s1_next;
         shutdown_n_s2_reg <= shutdown_n_s2_next;
      end
   end

   // Data bit from the link domain, single bit so two flops suffice
   logic bit_s1_reg, bit_s1_next, bit_s2_reg, bit_s2_next;

   always_comb begin
      bit_s1_next = bit_reg;
      bit_s2_next = bit_s1_reg;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         bit_s1_reg <= 1'b0;
         bit_s2_reg <= 1'b0;
      end else begin
         bit_s1_reg <= bit_s1_next;
         bit_s2_reg <= bit_s2_next;
      end
   end

   // ****************************************
   // Core domain: pin drivers
   // ****************************************
   sar_pin_t pin_reg, pin_next;
   logic hold_reg, hold_next;
   logic shutdown_n_reg, shutdown_n_next;
   logic cs_b_s, shutdown_n_s;

   assign cs_b_s = cs_s2_reg;
   assign shutdown_n_s = shutdown_n_s2_reg;

   always_comb begin
      pin_next = pin_drive(cs_b_s, bit_s2_reg);
      hold_next = ~cs_b_s;
      shutdown_n_next = ~shutdown_n_s;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pin_reg <= '0;
         hold_reg <= 1'b0;
         shutdown_n_reg <= 1'b0;
      end else begin
         pin_reg <= pin_next;
         hold_reg <= hold_next;
         shutdown_n_reg <= shutdown_n_next;
      end
   end

   assign o_dout = pin_reg.data;
   assign o_dout_oe = pin_reg.oe;
   assign o_hold = hold_reg;
   assign o_ref_en = ~shutdown_n_reg;
   assign o_low_power = shutdown_n_reg;
endmodule
`default_nettype wire

// file: testbench/sar_readout_sva.sv
// Checker of the readout port timing
`timescale 1ns/10ps
`default_nettype none
module sar_readout_sva (
   input wire logic i_core_clk, // clk
   input wire logic i_rst_b, // rst
   input wire logic i_sclk, // link clk
   input wire logic i_cs_b, // select
   input wire logic i_shutdown_n, // shutdown
   input wire logic o_dout, // data
   input wire logic o_dout_oe, // oe
   input wire logic o_hold, // hold
   input wire logic o_ref_en, // ref
   input wire logic o_low_power // lowpow
);
   default clocking dc @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   a_drive_low: assert property ($fell(i_cs_b) |-> ##3 o_dout_oe && !o_dout && o_hold) else $error("start");
   a_hold_frame: assert property (!i_cs_b [*4] |-> o_hold && o_dout_oe) else $error("hold");
   a_dout_after_rise: assert property ($changed(o_dout) && o_dout_oe |-> $past(i_sclk, 3) && !$past(i_sclk, 4))
      else $error("edge");
   a_hiz_idle: assert property (i_cs_b [*4] |-> !o_dout_oe && !o_dout) else $error("hiz");
   a_cs_release: assert property ($rose(i_cs_b) |-> ##3 !o_dout_oe && !o_hold) else $error("end");
   a_ref_off: assert property (!i_shutdown_n [*4] |-> !o_ref_en) else $error("ref off");
   a_ref_on: assert property (i_shutdown_n [*4] |-> o_ref_en) else $error("ref on");
   a_low_power: assert property (o_low_power != o_ref_en) else $error("mode");
endmodule
bind sar_readout sar_readout_sva i_sva (.i_core_clk, .i_rst_b, .i_sclk, .i_cs_b, .i_shutdown_n, .o_dout,
   .o_dout_oe, .o_hold, .o_ref_en, .o_low_power);
`default_nettype wire

// file: testbench/sar_host.sv
// Serial master model driving select and link clock
`timescale 1ns/10ps
`default_nettype none
module sar_host (
   output logic o_cs_b, // select
   output logic o_sclk, // link clk
   input wire logic i_dout, // data
   input wire logic i_dout_oe, // oe
   output logic [31:0] o_rx // captured bits
);
   initial begin
      o_cs_b = 1'b1;
      o_sclk = 1'b0;
   end
   // Undriven line reads unknown
   always @(negedge o_sclk) o_rx <= {o_rx[30:0], i_dout_oe ? i_dout : 1'bx};
   task automatic frame(input int n);
      o_rx = 32'h0;
      #7 o_cs_b = 1'b0;
      #100;
      repeat (n) begin
         o_sclk = 1'b1;
         #32 o_sclk = 1'b0;
         #32;
      end
      o_cs_b = 1'b1;
      #150;
   endtask
endmodule
`default_nettype wire

// file: testbench/sar_readout_tb.sv
// Bench of the converter readout
`timescale 1ns/10ps
`default_nettype none
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t bad", $time); end end
module sar_readout_tb;
   import sar_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_shutdown_n = 1'b1;
   logic [RES_BITS-1:0] i_code = 10'h000;
   logic [SUB_BITS-1:0] i_sub = 2'h0;
   logic cs_b, sclk, dout, oe, hold, ref_en, low_power;
   logic [31:0] rx;
   int n_fail = 0;
   int num_checks = 0;
   sar_readout i_sar_readout (.i_core_clk, .i_rst_b, .i_sclk(sclk), .i_cs_b(cs_b), .i_shutdown_n, .i_code, .i_sub,
      .o_dout(dout), .o_dout_oe(oe), .o_hold(hold), .o_ref_en(ref_en), .o_low_power(low_power));
   sar_host i_sar_host (.o_cs_b(cs_b), .o_sclk(sclk), .i_dout(dout), .i_dout_oe(oe), .o_rx(rx));
   initial forever #12.5 i_core_clk = ~i_core_clk;
   task automatic t_frames();
      logic [9:0] c[3] = '{10'h000, 10'h3ff, 10'h2a5};
      foreach (c[i]) begin
         @(posedge i_core_clk) #1 i_code = c[i];
         i_sub = c[i][1:0] ^ 2'h1;
         i_sar_host.frame(15);
         `CK(rx[14:0], {3'h0, c[i], c[i][1:0] ^ 2'h1})
      end
      i_sar_host.frame(16);
      `CK(rx[15:8], {3'h0, 5'h15})
      `CK(rx[7:0], {5'h05, 2'h0, 1'h0})
      i_sar_host.frame(20);
      `CK(rx[19:0], {3'h0, 10'h2a5, 2'h0, 5'h00})
   endtask
   task automatic t_abort();
      i_sar_host.frame(5);
      `CK(oe, 1'b0)
      `CK(hold, 1'b0)
      i_sar_host.frame(13);
      `CK(rx[12:0], {3'h0, 10'h2a5})
   endtask
   task automatic t_shut();
      @(posedge i_core_clk) #1 i_shutdown_n = 1'b0;
      repeat (6) @(posedge i_core_clk);
      #1 `CK({ref_en, low_power}, 2'h1)
      i_shutdown_n = 1'b1;
      repeat (6) @(posedge i_core_clk);
      #1 `CK({ref_en, low_power}, 2'h2)
   endtask
   task automatic print_verdict();
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge i_core_clk);
      #1 i_rst_b = 1'b1;
      t_frames();
      t_abort();
      t_shut();
      print_verdict();
   end
   initial begin
      #50000 n_fail++;
      print_verdict();
   end
endmodule
`default_nettype wire
